/* common/sdes_pkg.sv */
/*
 * Package for the switch drop event status block: register offsets,
 * field positions, reset values, drop cause codes and bus carriers.
 * Assumes an AXI4-Lite slave with 32-bit data and word-aligned access.
 */
package sdes_pkg;

	localparam logic [11:0] OFF_STATUS = 12'h000;
	localparam logic [11:0] OFF_MASK   = 12'h004;

	localparam int B_CAUSE_HI = 14;
	localparam int B_CAUSE_LO = 11;
	localparam int B_PORT_HI  = 10;
	localparam int B_PORT_LO  = 9;
	localparam int B_VALID    = 8;
	localparam int A_CAUSE_HI = 7;
	localparam int A_CAUSE_LO = 4;
	localparam int A_PORT_HI  = 3;
	localparam int A_PORT_LO  = 2;
	localparam int A_VALID    = 1;
	localparam int PENDING    = 0;

	localparam logic       MASK_RESET = 1'h1;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		CAUSE_UNTAGGED      = 4'h0,
		CAUSE_SRC_NOT_MEM_U = 4'h1,
		CAUSE_SRC_BLOCKED   = 4'h2,
		CAUSE_DST_BLOCKED   = 4'h3,
		CAUSE_DST_NOT_MEM   = 4'h4,
		CAUSE_SRC_NOT_MEM_K = 4'h5,
		CAUSE_UNK_UNICAST   = 4'h6,
		CAUSE_UNK_MCAST     = 4'h7,
		CAUSE_BCAST_LIMIT   = 4'h8,
		CAUSE_SRC_BLOCKED_U = 4'h9,
		CAUSE_SAME_PORT     = 4'ha,
		CAUSE_FILTERED      = 4'hb,
		CAUSE_VID_FFF       = 4'he
	} sdes_cause_t;

	localparam logic [11:0] VID_RESERVED = 12'hfff;

	// Facts about one dropped frame, as offered by the forwarding engine.
	typedef struct packed {
		logic       drop;
		logic [1:0] port;
		logic       tagged_only_admit;
		logic       untagged;
		logic       membership_check;
		logic       admit_non_member;
		logic       src_member;
		logic       dst_member;
		logic       found;
		logic       src_forwarding;
		logic       dst_forwarding;
		logic       dst_same_port;
		logic       filter_flag;
		logic       drop_unknown;
		logic       filter_multicast;
		logic       is_unicast;
		logic       is_multicast;
		logic       bcast_over_limit;
		logic [11:0] vid;
	} sdes_drop_t;

	typedef struct packed {
		logic        valid;
		logic [3:0]  cause;
		logic [1:0]  port;
	} sdes_capture_t;

endpackage : sdes_pkg

/* src/sdes_drop_status.sv */
/*
 * Drop event status capture with AXI4-Lite register access.
 * Assumes the forwarding engine presents one drop descriptor per cycle,
 * synchronous to aclk, with drop high for exactly the frames dropped.
 */
// Behaviour
// - Set-B cause sits in bits 14:11, meaningful while bit 8 set.
// - Code 0000: tagged-only admit and untagged or priority-tagged frame.
// - Source not VLAN member: 0001 if destination unknown, 0101 if found.
// - Found destination: 0010 source not forwarding, 0011 destination not.
// - Code 0100: found destination not member of frame's VLAN.
// - Code 0110: drop-unknown set and unicast destination missing.
// - Code 0111: multicast filtering set and multicast destination missing.
// - Code 1000: broadcast over throttling limit.
// - Code 1001: unknown or broadcast destination, source not forwarding.
// - Code 1010: found destination equals ingress port.
// - Code 1011: found destination entry has its filter flag.
// - Code 1110 for VLAN FFFh; codes 1100, 1101, 1111 never reported.
// - Set-B ingress port in bits 10:9, valid while bit 8 set.
// - Set-B valid bit 8 marks capture; resets zero, clears on read.
// - Set-A cause in bits 7:4, same encoding, valid while bit 1.
// - Set-A ingress port in bits 3:2, valid while bit 1 set.
// - Set-A valid bit 1 marks capture; resets zero, clears on read.
// - Pending bit 0 set by any drop; resets zero, clears on read.
// - Two capture sets hold a second drop while first awaits a read.
// - Mask bit, set at reset, suppresses interrupt but not status.
`timescale 1ns/1ps
module sdes_drop_status (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              clk_en,
	input  wire sdes_pkg::sdes_drop_t drop_in,
	input  wire logic [11:0]       s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [11:0]       s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic                   switch_irq
);
	import sdes_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Cause encoding. Order sets precedence when several causes hold.

	sdes_cause_t next_cause;

	always_comb begin
		next_cause = CAUSE_UNTAGGED;
		if (drop_in.vid == VID_RESERVED) begin
			next_cause = CAUSE_VID_FFF;
		end else if (drop_in.tagged_only_admit && drop_in.untagged) begin
			next_cause = CAUSE_UNTAGGED;
		end else if (drop_in.bcast_over_limit) begin
			next_cause = CAUSE_BCAST_LIMIT;
		end else if (!drop_in.found) begin
			if (drop_in.membership_check && !drop_in.admit_non_member &&
			    !drop_in.src_member) begin
				next_cause = CAUSE_SRC_NOT_MEM_U;
			end else if (!drop_in.src_forwarding) begin
				next_cause = CAUSE_SRC_BLOCKED_U;
			end else if (drop_in.drop_unknown && drop_in.is_unicast) begin
				next_cause = CAUSE_UNK_UNICAST;
			end else begin
				next_cause = CAUSE_UNK_MCAST;
			end
		end else begin
			if (drop_in.filter_flag) begin
				next_cause = CAUSE_FILTERED;
			end else if (drop_in.dst_same_port) begin
				next_cause = CAUSE_SAME_PORT;
			end else if (!drop_in.src_forwarding) begin
				next_cause = CAUSE_SRC_BLOCKED;
			end else if (!drop_in.dst_forwarding) begin
				next_cause = CAUSE_DST_BLOCKED;
			end else if (drop_in.membership_check &&
			             !drop_in.admit_non_member &&
			             !drop_in.src_member) begin
				next_cause = CAUSE_SRC_NOT_MEM_K;
			end else begin
				next_cause = CAUSE_DST_NOT_MEM;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite handshakes. One word per access; ready is a one-cycle pulse.

	logic aw_hold;
	logic w_hold;
	logic [11:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        do_write;
	logic        do_read;

	assign do_write = aw_hold && w_hold && !s_axi_bvalid;
	assign do_read  = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold       <= 1'b0;
			w_hold        <= 1'b0;
			aw_addr       <= 12'h000;
			w_data        <= 32'h00000000;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else if (clk_en) begin
			s_axi_awready <= s_axi_awvalid && !aw_hold && !s_axi_awready;
			s_axi_wready  <= s_axi_wvalid && !w_hold && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_hold      <= 1'b0;
				w_hold       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_addr[11:2] == OFF_MASK[11:2] ||
				                 aw_addr[11:2] == OFF_STATUS[11:2]) ?
				                RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Mask register.

	logic mask;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mask <= MASK_RESET;
		end else if (clk_en && do_write && w_strb[0] &&
		             aw_addr[11:2] == OFF_MASK[11:2]) begin
			mask <= w_data[0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Capture sets. A read clears what it returned; a drop landing in the
	// read cycle is kept, because it loads into the set the read frees.

	sdes_capture_t set_a;
	sdes_capture_t set_b;
	logic          pending;
	logic          status_read;
	logic [31:0]   status_word;

	assign status_read = clk_en && do_read &&
	                     s_axi_araddr[11:2] == OFF_STATUS[11:2];

	always_comb begin
		status_word = 32'h00000000;
		status_word[B_CAUSE_HI:B_CAUSE_LO] = set_b.cause;
		status_word[B_PORT_HI:B_PORT_LO]   = set_b.port;
		status_word[B_VALID]               = set_b.valid;
		status_word[A_CAUSE_HI:A_CAUSE_LO] = set_a.cause;
		status_word[A_PORT_HI:A_PORT_LO]   = set_a.port;
		status_word[A_VALID]               = set_a.valid;
		status_word[PENDING]               = pending;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			set_a   <= '0;
			set_b   <= '0;
			pending <= 1'b0;
		end else if (clk_en) begin
			if (status_read) begin
				set_a   <= '0;
				set_b   <= '0;
				pending <= 1'b0;
			end
			if (drop_in.drop) begin
				pending <= 1'b1;
				if (status_read || !set_a.valid) begin
					set_a <= '{1'b1, 4'(next_cause), drop_in.port};
				end else if (!set_b.valid) begin
					set_b <= '{1'b1, 4'(next_cause), drop_in.port};
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read channel and interrupt.

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= RESP_OKAY;
		end else if (clk_en) begin
			s_axi_arready <= do_read;
			if (do_read) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= RESP_OKAY;
				if (s_axi_araddr[11:2] == OFF_STATUS[11:2]) begin
					s_axi_rdata <= status_word;
				end else if (s_axi_araddr[11:2] == OFF_MASK[11:2]) begin
					s_axi_rdata <= {31'h00000000, mask};
				end else begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= RESP_SLVERR;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			switch_irq <= 1'b0;
		end else if (clk_en) begin
			switch_irq <= pending && !mask && !status_read;
		end
	end

endmodule : sdes_drop_status

/* verif/sdes_drop_status_chk.sv */
/*
 * Checker for the drop status block: bus handshakes and status word.
 * Assumes it is bound to the ports of sdes_drop_status.
 */
`timescale 1ns/1ps
module sdes_chk
	import sdes_pkg::*;
(
	input wire logic                 aclk,
	input wire logic                 aresetn,
	input wire logic                 clk_en,
	input wire sdes_pkg::sdes_drop_t drop_in,
	input wire logic                 s_axi_awvalid,
	input wire logic                 s_axi_awready,
	input wire logic                 s_axi_bvalid,
	input wire logic                 s_axi_bready,
	input wire logic                 s_axi_arvalid,
	input wire logic                 s_axi_arready,
	input wire logic [31:0]          s_axi_rdata,
	input wire logic [1:0]           s_axi_rresp,
	input wire logic                 s_axi_rvalid,
	input wire logic                 s_axi_rready,
	input wire logic                 switch_irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////////////
	rd_answer_a: assert property (clk_en && s_axi_arvalid && !s_axi_rvalid
		|=> s_axi_rvalid && s_axi_arready) else $error("read not answered");
	ar_pulse_a: assert property (s_axi_arready |=> !s_axi_arready)
		else $error("arready held");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read lost");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid) else $error("write response lost");
	wr_answer_a: assert property (s_axi_awvalid && s_axi_awready
		|-> ##[1:3] s_axi_bvalid) else $error("write not answered");
	err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR
		|-> s_axi_rdata == 32'h0) else $error("error read has data");
	high_zero_a: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:15] == 17'h0)
		else $error("upper bits set");
	rsv_cause_a: assert property (
		s_axi_rvalid && s_axi_rdata[1]
		|-> !(s_axi_rdata[7:4] inside {4'hc, 4'hd, 4'hf}))
		else $error("reserved cause in set A");
	rsv_cause_b_a: assert property (
		s_axi_rvalid && s_axi_rdata[8]
		|-> !(s_axi_rdata[14:11] inside {4'hc, 4'hd, 4'hf}))
		else $error("reserved cause in set B");
	set_order_a: assert property (
		s_axi_rvalid && (s_axi_rdata[8] || s_axi_rdata[1])
		|-> s_axi_rdata[1] && s_axi_rdata[0]) else $error("set order");
	drop_c: cover property (clk_en && drop_in.drop);
	both_c: cover property (s_axi_rvalid && s_axi_rdata[8]);
	irq_c: cover property (switch_irq);
endmodule : sdes_chk

bind sdes_drop_status sdes_chk u_chk (.*);

/* verif/sdes_drop_status_tb.sv */
/*
 * Self-checking bench: drives drop descriptors and an AXI4-Lite master.
 * Assumes the checker is bound from its own file.
 */
`timescale 1ns/1ps
module switch_drop_event_status_tb;
	import sdes_pkg::*;
	logic        aclk = 1'h0;
	logic        aresetn = 1'h0;
	logic        clk_en = 1'h1;
	sdes_drop_t  drop_in = '0;
	logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
	logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
	logic        s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, switch_irq;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	int          n_mismatch = 0, checked = 0, cyc = 0;
	localparam logic [3:0] CODES [13] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4,
		4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'he};

	sdes_drop_status u_dut (.*);

	always #5 aclk = ~aclk;
	////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : finish_test

	// A hung handshake would otherwise stall the run forever.
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			finish_test();
		end
	end

	task automatic chk(input string n, input logic [31:0] e, g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// Handshakes are judged on the values sampled at the rising edge; the
	// release is scheduled by non-blocking assignment at that same edge.
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		logic b;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			b = s_axi_bvalid;
			r = s_axi_bresp;
		end while (!b);
		s_axi_bready <= 1'h0;
	endtask : wr

	task automatic rd(input logic [11:0] a);
		logic b;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			b = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
		end while (!b);
		s_axi_rready <= 1'h0;
	endtask : rd

	function automatic sdes_drop_t mk(input logic [3:0] c, input logic [1:0] p);
		sdes_drop_t x;
		x = '0;
		{x.drop, x.src_member, x.dst_member} = 3'h7;
		{x.src_forwarding, x.dst_forwarding} = 2'h3;
		x.port = p;
		x.vid = 12'h001;
		case (c)
		4'h0: {x.tagged_only_admit, x.untagged} = 2'h3;
		4'h1: {x.membership_check, x.src_member} = 2'h2;
		4'h2: {x.found, x.src_forwarding} = 2'h2;
		4'h3: {x.found, x.dst_forwarding} = 2'h2;
		4'h4: {x.found, x.membership_check, x.dst_member} = 3'h6;
		4'h5: {x.found, x.membership_check, x.src_member} = 3'h6;
		4'h6: {x.drop_unknown, x.is_unicast} = 2'h3;
		4'h7: {x.filter_multicast, x.is_multicast} = 2'h3;
		4'h8: x.bcast_over_limit = 1'h1;
		4'h9: x.src_forwarding = 1'h0;
		4'ha: {x.found, x.dst_same_port} = 2'h3;
		4'hb: {x.found, x.filter_flag} = 2'h3;
		default: x.vid = VID_RESERVED;
		endcase
		return x;
	endfunction : mk

	task automatic drive(input sdes_drop_t x);
		@(posedge aclk);
		drop_in <= x;
		@(posedge aclk);
		drop_in <= '0;
	endtask : drive
	////////////////////////////////////////////////////////////////////
	task automatic test_reset();
		rd(OFF_STATUS);
		chk("status reset", 32'h0, d);
		rd(OFF_MASK);
		chk("mask reset", {31'h0, MASK_RESET}, d);
		$display("reset test done");
	endtask : test_reset

	task automatic test_cause();
		for (int i = 0; i < 13; i++) begin
			drive(mk(CODES[i], 2'(i % 3)));
			rd(OFF_STATUS);
			chk("cause", {24'h0, CODES[i], 2'(i % 3), 2'h3}, d);
		end
		$display("cause test done");
	endtask : test_cause

	task automatic test_sets();
		@(posedge aclk);
		drop_in <= mk(4'h8, 2'h2);
		@(posedge aclk);
		drop_in <= mk(4'ha, 2'h1);
		@(posedge aclk);
		drop_in <= mk(4'hb, 2'h0);
		@(posedge aclk);
		drop_in <= '0;
		rd(OFF_STATUS);
		chk("two sets", {17'h0, 4'ha, 2'h1, 1'h1, 4'h8, 2'h2, 2'h3}, d);
		rd(OFF_STATUS);
		chk("cleared", 32'h0, d);
		$display("set test done");
	endtask : test_sets

	// A drop offered while the clock enable is low must leave no trace.
	task automatic test_freeze();
		@(posedge aclk);
		clk_en <= 1'h0;
		drive(mk(4'h2, 2'h1));
		clk_en <= 1'h1;
		rd(OFF_STATUS);
		chk("frozen drop", 32'h0, d);
		$display("freeze test done");
	endtask : test_freeze

	task automatic test_mask();
		drive(mk(4'h3, 2'h1));
		repeat (3) @(posedge aclk);
		@(negedge aclk);
		chk("irq masked", 32'h0, {31'h0, switch_irq});
		wr(OFF_MASK, 32'h0);
		repeat (3) @(posedge aclk);
		@(negedge aclk);
		chk("irq open", 32'h1, {31'h0, switch_irq});
		wr(OFF_MASK, 32'h1);
		repeat (3) @(posedge aclk);
		@(negedge aclk);
		chk("irq remasked", 32'h0, {31'h0, switch_irq});
		rd(OFF_STATUS);
		chk("kept status", {24'h0, 4'h3, 2'h1, 2'h3}, d);
		$display("mask test done");
	endtask : test_mask

	task automatic test_unmapped();
		rd(12'h008);
		chk("bad read", {30'h0, RESP_SLVERR}, {30'h0, r});
		wr(12'h008, 32'h1);
		chk("bad write", {30'h0, RESP_SLVERR}, {30'h0, r});
		$display("unmapped test done");
	endtask : test_unmapped

	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		test_reset();
		test_cause();
		test_sets();
		test_freeze();
		test_mask();
		test_unmapped();
		finish_test();
	end
endmodule : switch_drop_event_status_tb
